// ===== core/mnc_pkg.sv
// constants for the main path oscillator control registers
// assumes an 8-bit register port with 9-bit addresses and two main paths
package mnc_pkg;
  localparam int          NP           = 2;
  localparam int          NB           = 6;
  localparam int          AW           = 9;
  localparam int          TW_W         = 48;
  // -------------------------------------------------
  // register addresses
  // -------------------------------------------------
  localparam logic [8:0]  ADDR_CFG     = 9'h112;
  localparam logic [8:0]  ADDR_UPD     = 9'h113;
  localparam logic [8:0]  ADDR_TW0     = 9'h114;
  localparam logic [8:0]  ADDR_TW5     = 9'h119;
  // -------------------------------------------------
  // path config fields
  // -------------------------------------------------
  localparam int          CFG_MODE_LSB = 4;
  localparam int          CFG_EN_BIT   = 3;
  localparam int          CFG_MOD_BIT  = 2;
  localparam int          CFG_SB_BIT   = 1;
  localparam int          CFG_FOL_BIT  = 0;
  localparam logic [1:0]  RST_MODE     = 2'h0;
  localparam logic        RST_EN       = 1'b0;
  localparam logic        RST_MOD      = 1'b0;
  localparam logic        RST_SB       = 1'b0;
  localparam logic        RST_FOL      = 1'b1;
  // -------------------------------------------------
  // update control fields
  // -------------------------------------------------
  localparam int          UPD_AUTO_LSB = 4;
  localparam int          UPD_SYNC_BIT = 2;
  localparam int          UPD_ACK_BIT  = 1;
  localparam int          UPD_REQ_BIT  = 0;
  localparam logic [2:0]  RST_AUTO     = 3'h0;
  localparam logic [2:0]  AUTO_OFF     = 3'h0;
  localparam logic [2:0]  AUTO_BYTE0   = 3'h1;
  localparam logic [7:0]  RD_NONE      = 8'h00;
  localparam logic [47:0] RST_TW       = 48'h0;
endpackage

// ===== core/mnc_sync_edge.sv
// two-flop synchroniser for an asynchronous pin with rising-edge pulse
// assumes the pin is a level from outside the clk domain
`timescale 1ns/1ps
module mnc_sync_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin and pulse
  input  wire logic pin,
  output logic      rise
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~last_reg;
endmodule

// ===== core/mnc_main_nco_config_control.sv
// main path oscillator configuration and tuning-word load control
// assumes a register port from the serial control decoder, page mask from paging reg
//
// Function
// - bit 3 enables main oscillator, reset 0
// - bit 2 enables fractional modulus, reset 0
// - bit 1 picks lower sideband when set
// - bit 0 set: channels follow main loads
// - bit 0 clear: channels use own requests
// - every control held per path, page-selected
// - auto mode 000: byte writes never load
// - codes 001-110 load after bytes 0-5
// - request rising edge loads tuning word
// - ack set on load, cleared writing request 0
// - tuning word is 48 bits, frequency ratio
// - sync-load bit loads on next sync edge
`timescale 1ns/1ps
module mnc_main_nco_config_control
  import mnc_pkg::*;
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // register port
  input  wire logic [mnc_pkg::AW-1:0]        reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  // paging
  input  wire logic [mnc_pkg::NP-1:0]        main_path_page_select,
  // sync pin and channel requests
  input  wire logic                          sync_edge_pin,
  input  wire logic [mnc_pkg::NP-1:0]        chan_update_req,
  // per-path controls
  output logic      [mnc_pkg::NP-1:0]        main_osc_enable,
  output logic      [mnc_pkg::NP-1:0]        fractional_modulus_enable,
  output logic      [mnc_pkg::NP-1:0]        sideband_select,
  output logic      [mnc_pkg::NP-1:0][1:0]   modulator_mode,
  output logic      [mnc_pkg::NP-1:0][47:0]  active_tuning_word,
  output logic      [mnc_pkg::NP-1:0]        osc_load_pulse,
  output logic      [mnc_pkg::NP-1:0]        chan_osc_update
);
  import mnc_pkg::*;

  // ---------------------------------------------------------------
  // shared decode
  // ---------------------------------------------------------------
  logic               sync_rise;
  logic               hit_cfg;
  logic               hit_upd;
  logic               hit_tw;
  logic [2:0]         tw_idx;
  logic [2:0]         tw_code;
  logic [AW-1:0]      tw_off;
  logic [NP-1:0]      follow_reg;
  logic [NP-1:0]      sync_load_reg;
  logic [NP-1:0]      req_reg;
  logic [NP-1:0]      ack_reg;
  logic [NP-1:0][2:0] auto_reg;
  logic [NP-1:0][47:0] tw_reg;
  logic [NP-1:0][47:0] tw_next;
  logic [NP-1:0]      load;
  logic [NP-1:0]      auto_fire;
  logic [NP-1:0]      sw_rise;
  logic [NP-1:0]      sync_fire;
  logic [NP-1:0]      wr_cfg;
  logic [NP-1:0]      wr_upd;
  logic [NP-1:0]      wr_tw;
  logic               rd_path;
  logic [7:0]         rd_value;

  mnc_sync_edge u_sync (
    .clk  (clk),
    .rst  (rst),
    .pin  (sync_edge_pin),
    .rise (sync_rise)
  );

  assign hit_cfg = (reg_addr == ADDR_CFG);
  assign hit_upd = (reg_addr == ADDR_UPD);
  assign hit_tw  = (reg_addr >= ADDR_TW0) && (reg_addr <= ADDR_TW5);
  assign tw_off  = reg_addr - ADDR_TW0;
  assign tw_idx  = tw_off[2:0];
  assign tw_code = tw_idx + AUTO_BYTE0;

  // ---------------------------------------------------------------
  // per-path register copies
  // ---------------------------------------------------------------
  for (genvar p = 0; p < NP; p++) begin : g_path
    assign wr_cfg[p]    = reg_wr & main_path_page_select[p] & hit_cfg;
    assign wr_upd[p]    = reg_wr & main_path_page_select[p] & hit_upd;
    assign wr_tw[p]     = reg_wr & main_path_page_select[p] & hit_tw;
    assign sw_rise[p]   = wr_upd[p] & reg_wdata[UPD_REQ_BIT] & ~req_reg[p];
    assign auto_fire[p] = wr_tw[p] & (auto_reg[p] != AUTO_OFF) & (auto_reg[p] == tw_code);
    assign sync_fire[p] = sync_load_reg[p] & sync_rise;
    assign load[p]      = sw_rise[p] | auto_fire[p] | sync_fire[p];

    for (genvar b = 0; b < NB; b++) begin : g_byte
      assign tw_next[p][8*b +: 8] = (wr_tw[p] && tw_idx == 3'(b)) ?
                                    reg_wdata : tw_reg[p][8*b +: 8];
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        main_osc_enable[p]           <= RST_EN;
        fractional_modulus_enable[p] <= RST_MOD;
        sideband_select[p]           <= RST_SB;
        follow_reg[p]                <= RST_FOL;
        modulator_mode[p]            <= RST_MODE;
      end else if (wr_cfg[p]) begin
        main_osc_enable[p]           <= reg_wdata[CFG_EN_BIT];
        fractional_modulus_enable[p] <= reg_wdata[CFG_MOD_BIT];
        sideband_select[p]           <= reg_wdata[CFG_SB_BIT];
        follow_reg[p]                <= reg_wdata[CFG_FOL_BIT];
        modulator_mode[p]            <= reg_wdata[CFG_MODE_LSB +: 2];
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        auto_reg[p]      <= RST_AUTO;
        req_reg[p]       <= 1'b0;
        sync_load_reg[p] <= 1'b0;
      end else if (wr_upd[p]) begin
        auto_reg[p]      <= reg_wdata[UPD_AUTO_LSB +: 3];
        req_reg[p]       <= reg_wdata[UPD_REQ_BIT];
        sync_load_reg[p] <= reg_wdata[UPD_SYNC_BIT];
      end else if (sync_fire[p]) begin
        // one-shot: armed again only by software
        sync_load_reg[p] <= 1'b0;
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ack_reg[p] <= 1'b0;
      end else if (load[p]) begin
        ack_reg[p] <= 1'b1;
      end else if (wr_upd[p] && !reg_wdata[UPD_REQ_BIT]) begin
        ack_reg[p] <= 1'b0;
      end
    end

    // full 48-bit word moves to the oscillator at once
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        tw_reg[p]             <= RST_TW;
        active_tuning_word[p] <= RST_TW;
      end else begin
        tw_reg[p] <= tw_next[p];
        if (load[p]) begin
          active_tuning_word[p] <= tw_next[p];
        end
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        osc_load_pulse[p]  <= 1'b0;
        chan_osc_update[p] <= 1'b0;
      end else begin
        osc_load_pulse[p]  <= load[p];
        chan_osc_update[p] <= follow_reg[p] ? load[p] : chan_update_req[p];
      end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    AST_EN_WRITE: assert property (@(posedge clk) disable iff (rst)
      wr_cfg[p] |=> main_osc_enable[p] == $past(reg_wdata[CFG_EN_BIT]))
      else $error("enable bit did not take written value");
    AST_MOD_SB_HOLD: assert property (@(posedge clk) disable iff (rst)
      !wr_cfg[p] |=> $stable(fractional_modulus_enable[p]) && $stable(sideband_select[p]))
      else $error("modulus or sideband changed without write");
    AST_SB_WRITE: assert property (@(posedge clk) disable iff (rst)
      wr_cfg[p] ##1 !wr_cfg[p] |=> sideband_select[p] == $past(reg_wdata[CFG_SB_BIT], 2))
      else $error("sideband bit lost");
    AST_PAGE_ISOLATE: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && hit_cfg && !main_path_page_select[p]) |=> $stable(main_osc_enable[p]))
      else $error("unselected path copy changed");
    AST_FOLLOW_MAIN: assert property (@(posedge clk) disable iff (rst)
      (load[p] && follow_reg[p]) |=> chan_osc_update[p] && osc_load_pulse[p])
      else $error("channel did not follow main load");
    AST_OWN_REQ: assert property (@(posedge clk) disable iff (rst)
      (!follow_reg[p] && !chan_update_req[p]) |=> !chan_osc_update[p])
      else $error("channel updated without own request");
    AST_AUTO_OFF: assert property (@(posedge clk) disable iff (rst)
      (wr_tw[p] && auto_reg[p] == AUTO_OFF && !sync_fire[p]) |=> !osc_load_pulse[p])
      else $error("load with auto mode off");
    AST_AUTO_LOAD: assert property (@(posedge clk) disable iff (rst)
      (wr_tw[p] && auto_reg[p] == tw_code) |=> osc_load_pulse[p] && ack_reg[p]
        && active_tuning_word[p] == tw_reg[p])
      else $error("auto load missing or wrong word");
    AST_ACK_CLEAR: assert property (@(posedge clk) disable iff (rst)
      (wr_upd[p] && !reg_wdata[UPD_REQ_BIT] && !load[p]) |=> !ack_reg[p] ##1 !ack_reg[p] ||
        $past(load[p], 1) || load[p])
      else $error("ack not cleared");
    AST_SYNC_LOAD: assert property (@(posedge clk) disable iff (rst)
      (sync_load_reg[p] && sync_rise && !wr_upd[p]) |=> osc_load_pulse[p] && !sync_load_reg[p])
      else $error("sync edge did not load");
  end

  // ---------------------------------------------------------------
  // read-back from lowest selected page
  // ---------------------------------------------------------------
  assign rd_path  = ~main_path_page_select[0];
  assign rd_value = hit_cfg ? {2'b00, modulator_mode[rd_path], main_osc_enable[rd_path],
                               fractional_modulus_enable[rd_path], sideband_select[rd_path],
                               follow_reg[rd_path]} :
                    hit_upd ? {1'b0, auto_reg[rd_path], 1'b0, sync_load_reg[rd_path],
                               ack_reg[rd_path], req_reg[rd_path]} :
                    hit_tw  ? tw_reg[rd_path][8*tw_idx +: 8] : RD_NONE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= RD_NONE;
    end else if (reg_rd) begin
      reg_rdata <= rd_value;
    end
  end
endmodule

// ===== test/test_main_nco_config_control.sv
// bench for the main path oscillator control registers
// assumes mnc_pkg and the design are compiled first
`timescale 1ns/1ps
module test_main_nco_config_control;
  import mnc_pkg::*;
  logic              clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sync_edge_pin = 0;
  logic [8:0]        reg_addr = '0;
  logic [7:0]        reg_wdata = '0, reg_rdata;
  logic [1:0]        pg = 2'h1, creq = '0, en, fm, sb, olp, cou;
  logic [1:0][1:0]   mm;
  logic [1:0][47:0]  atw;
  logic [7:0]        cfg [2], upd [2];
  logic [47:0]       tw [2], act [2];
  int                n_fail = 0, num_checks = 0, r;
  int                nl [2] = '{0, 0}, nc [2] = '{0, 0}, gl [2] = '{0, 0}, gc [2] = '{0, 0};

  always #5 clk = ~clk;

  mnc_main_nco_config_control DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_path_page_select(pg),
    .sync_edge_pin(sync_edge_pin), .chan_update_req(creq), .main_osc_enable(en),
    .fractional_modulus_enable(fm), .sideband_select(sb), .modulator_mode(mm),
    .active_tuning_word(atw), .osc_load_pulse(olp), .chan_osc_update(cou));

  // count every load and channel pulse the design emits
  always @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      gl[p] += olp[p];
      gc[p] += cou[p];
    end
  end

  // ----------------------------------------
  // checking and model
  // ----------------------------------------
  task automatic cmp_out(logic [47:0] g, logic [47:0] e, string m);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, g, e);
    end
  endtask

  task automatic cmp_rd(logic [7:0] g, logic [7:0] e);
    cmp_out(g, e, "read data");
  endtask

  task automatic load(int p);
    act[p] = tw[p];
    upd[p][1] = 1'b1;
    nl[p]++;
    if (cfg[p][0]) nc[p]++;
  endtask

  task automatic wr(logic [8:0] a, logic [7:0] d, logic [1:0] g);
    logic old;
    int k;
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    pg = g;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
    for (int p = 0; p < 2; p++) if (g[p]) begin
      if (a == ADDR_CFG) cfg[p] = d & 8'h3f;
      if (a == ADDR_UPD) begin
        old = upd[p][0];
        upd[p] = {1'b0, d[6:4], 1'b0, d[2], d[0] & upd[p][1], d[0]};
        if (d[0] && !old) load(p);
      end
      if (a >= ADDR_TW0 && a <= ADDR_TW5) begin
        k = int'(a - ADDR_TW0);
        tw[p][8*k +: 8] = d;
        if (upd[p][6:4] == k + 1) load(p);
      end
    end
  endtask

  task automatic rd(logic [8:0] a, logic [1:0] g);
    logic [7:0] e;
    int p;
    p = g[0] ? 0 : 1;
    e = RD_NONE;
    if (a == ADDR_CFG) e = cfg[p];
    if (a == ADDR_UPD) e = upd[p];
    if (a >= ADDR_TW0 && a <= ADDR_TW5) e = 8'(tw[p] >> (8 * int'(a - ADDR_TW0)));
    @(negedge clk);
    reg_addr = a;
    pg = g;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    @(negedge clk);
    cmp_rd(reg_rdata, e);
  endtask

  task automatic chk();
    repeat (3) @(negedge clk);
    for (int p = 0; p < 2; p++) begin
      cmp_out({en[p], fm[p], sb[p]}, cfg[p][3:1], "enables");
      cmp_out(mm[p], cfg[p][5:4], "mode");
      cmp_out(atw[p], act[p], "word");
      cmp_out(gl[p], nl[p], "loads");
      cmp_out(gc[p], nc[p], "channel updates");
    end
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    r = $urandom(32'hcea8);
    for (int p = 0; p < 2; p++) begin
      cfg[p] = 8'h01;
      upd[p] = 8'h00;
      tw[p] = RST_TW;
      act[p] = RST_TW;
    end
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 0;
    for (int p = 1; p < 3; p++) rd(ADDR_CFG, 2'(p));
    for (int p = 1; p < 3; p++) rd(ADDR_UPD, 2'(p));
    chk();
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CFG, 8'($urandom), 2'(1 + $urandom % 3));
      rd(ADDR_CFG, 2'h1);
      rd(ADDR_CFG, 2'h2);
      chk();
    end
    wr(9'h100, 8'hff, 2'h3);
    rd(9'h100, 2'h1);
    // code 7 and bits 7,3,1 written here must not take effect
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_UPD, {1'b1, 3'(m), 4'ha}, 2'h3);
      for (int k = 0; k < NB; k++) begin
        wr(ADDR_TW0 + 9'(k), 8'($urandom), 2'(1 + $urandom % 3));
      end
      rd(ADDR_UPD, 2'h2);
      rd(ADDR_TW0 + 9'(m % NB), 2'h1);
      chk();
    end
    wr(ADDR_UPD, 8'h01, 2'h1);
    wr(ADDR_UPD, 8'h01, 2'h1);
    rd(ADDR_UPD, 2'h1);
    chk();
    wr(ADDR_UPD, 8'h00, 2'h1);
    rd(ADDR_UPD, 2'h1);
    wr(ADDR_CFG, 8'h08, 2'h2);
    wr(ADDR_CFG, 8'h09, 2'h1);
    @(negedge clk);
    creq = 2'h3;
    @(negedge clk);
    creq = 2'h0;
    for (int p = 0; p < 2; p++) if (!cfg[p][0]) nc[p]++;
    chk();
    // no shift wanted: zero word loaded while the enables stay set
    for (int k = 0; k < NB; k++) wr(ADDR_TW0 + 9'(k), 8'h00, 2'h3);
    wr(ADDR_UPD, 8'h01, 2'h3);
    chk();
    wr(ADDR_TW5, 8'($urandom), 2'h3);
    wr(ADDR_UPD, 8'h04, 2'h1);
    @(negedge clk);
    sync_edge_pin = 1;
    repeat (8) @(negedge clk);
    sync_edge_pin = 0;
    load(0);
    upd[0][2] = 1'b0;
    chk();
    rd(ADDR_UPD, 2'h1);
    end_of_test();
  end
endmodule
